// File: usc_pkg.sv
// Package with the constants and types of the serial status and control block
//
// What this block does
// [RULE_01] Transmit interrupt mode 11 is reserved and raises no transmit interrupt.
// [RULE_02] Mode 10: interrupt when a character loads the shifter and the buffer empties.
// [RULE_03] Mode 01: interrupt after the last character is shifted out completely.
// [RULE_04] Mode 00: interrupt whenever a character loads the shifter, leaving a free slot.
// [RULE_05] Invert bit sets the pin idle level; with infrared on, the encoded idle level.
// [RULE_06] Break request makes the next frame a start bit, twelve zeros, a stop bit.
// [RULE_07] Hardware clears the break request once the break frame has finished.
// [RULE_08] With transmit enabled the transceiver drives the serial transmit pin.
// [RULE_09] Disabling transmit aborts the frame, flushes the buffer, returns the pin.
// [RULE_10] Shifter-empty flag reads one only when shifter and buffer are both empty.
// [RULE_11] Receive mode 11: interrupt when a received character fills the buffer to four.
// [RULE_12] Receive mode 10: interrupt when a received character leaves three in the buffer.
// [RULE_13] Receive mode 0x: interrupt on every character moved into the receive buffer.
// [RULE_14] Buffer-full flag is read-only and shows no further character can be taken.
// [RULE_15] Overrun is cleared by writing zero; parity, framing, idle, available read-only.
package usc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 3;
  localparam int unsigned REG_W         = 16;
  localparam logic [2:0]  OFS_STAT_CTRL = 3'h0;
  localparam logic [2:0]  OFS_IRQ_STAT  = 3'h1;
  localparam logic [2:0]  OFS_IRQ_MASK  = 3'h2;
  localparam logic [2:0]  OFS_TX_DATA   = 3'h3;
  localparam logic [2:0]  OFS_RX_DATA   = 3'h4;
  localparam logic [2:0]  OFS_EXT_CTRL  = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TXM_HI    = 15;
  localparam int unsigned BIT_TX_INV    = 14;
  localparam int unsigned BIT_TXM_LO    = 13;
  localparam int unsigned BIT_BREAK     = 11;
  localparam int unsigned BIT_TXEN      = 10;
  localparam int unsigned BIT_TXBF      = 9;
  localparam int unsigned BIT_SHIFT_MT  = 8;
  localparam int unsigned BIT_RXM_HI    = 7;
  localparam int unsigned BIT_RXM_LO    = 6;
  localparam int unsigned BIT_ADDR_DET  = 5;
  localparam int unsigned BIT_RX_IDLE   = 4;
  localparam int unsigned BIT_PAR_ERR   = 3;
  localparam int unsigned BIT_FRM_ERR   = 2;
  localparam int unsigned BIT_OVERRUN   = 1;
  localparam int unsigned BIT_RX_AVAIL  = 0;
  localparam int unsigned BIT_IR_EN     = 0;
  localparam int unsigned IRQ_TX        = 0;
  localparam int unsigned IRQ_RX        = 1;
  localparam int unsigned IRQ_OVERRUN   = 2;
  localparam int unsigned IRQ_RX_ERR    = 3;
  localparam int unsigned IRQ_W         = 4;

  // ----------------------------------------------------------------
  // Reset values and modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
  localparam logic [1:0]  TXM_EACH      = 2'h0;
  localparam logic [1:0]  TXM_DONE      = 2'h1;
  localparam logic [1:0]  TXM_EMPTY     = 2'h2;
  localparam logic [1:0]  TXM_RSVD      = 2'h3;
  localparam logic [1:0]  RXM_3Q        = 2'h2;
  localparam logic [1:0]  RXM_FULL      = 2'h3;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned BUF_DEPTH     = 4;
  localparam int unsigned RX_3Q_LEVEL   = 3;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned BREAK_ZEROS   = 12;
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned BAUD_HZ       = 625000;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_HZ;

  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic                 parity_err;
    logic                 framing_err;
  } usc_rx_char_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } usc_bus_req_t;
endpackage

// File: usc_remote_node.sv
// Remote serial node that decodes frames seen on the transmit line
`timescale 1ns/100ps
module usc_remote_node #(
  parameter int unsigned BC = 4
) (
  input  wire logic       clk_in,
  input  wire logic       line_in,
  output logic      [7:0] byte_out,
  output int              frames_out
);
  // Samples mid-bit, LSB first; a break decodes as a zero byte
  initial begin
    byte_out = 8'h00;
    frames_out = 0;
    forever begin
      @(negedge line_in);
      repeat (BC / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BC) @(posedge clk_in);
        byte_out[i] = line_in;
      end
      repeat (BC) @(posedge clk_in);
      frames_out++;
    end
  end
endmodule // usc_remote_node

// File: usc_status_control.sv
// Status, control, buffers and interrupts of one serial transmit and receive channel
`timescale 1ns/100ps
module usc_status_control #(
  parameter int unsigned BIT_CYCLES = usc_pkg::BIT_CYCLES,
  parameter int unsigned DEPTH      = usc_pkg::BUF_DEPTH
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_n_in,
  input  wire usc_pkg::usc_bus_req_t bus_req_in,
  output logic [usc_pkg::REG_W-1:0]  rd_data_out,
  input  wire logic                  rx_char_valid_in,
  input  wire usc_pkg::usc_rx_char_t rx_char_in,
  input  wire logic                  rx_line_idle_in,
  input  wire logic                  port_tx_value_in,
  output logic                       serial_tx_pin_out,
  output logic                       tx_pin_owned_out,
  output logic                       irq_out
);
  import usc_pkg::*;

  localparam logic [2:0] DEPTH_C = 3'(DEPTH);
  localparam logic [2:0] LVL_3Q  = 3'(RX_3Q_LEVEL);
  // Last sampled cycle of the thirteen low bit times of a break frame
  localparam int         BRK_LOW_LAST = (BREAK_ZEROS + 1) * BIT_CYCLES - 1;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]        tx_mode_q;
  logic              tx_invert_q;
  logic              break_q;
  logic              break_active_q;
  logic              txen_q;
  logic [1:0]        rx_mode_q;
  logic              addr_det_q;
  logic              overrun_q;
  logic              ir_en_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_evt;
  logic [REG_W-1:0]  rd_data_q;
  logic              irq_q;
  logic              pin_q;
  logic              owned_q;

  logic [7:0]        tx_mem [DEPTH];
  logic [1:0]        tx_wp_q;
  logic [1:0]        tx_rp_q;
  logic [2:0]        tx_cnt_q;
  usc_rx_char_t      rx_mem [DEPTH];
  logic [1:0]        rx_wp_q;
  logic [1:0]        rx_rp_q;
  logic [2:0]        rx_cnt_q;
  logic [2:0]        rx_cnt_next;

  logic              wr_ctrl;
  logic              wr_txd;
  logic              rd_rxd;
  logic              tx_full;
  logic              tx_push;
  logic              tx_load;
  logic              break_start;
  logic              tx_busy;
  logic              tx_done;
  logic              tx_line;
  logic              shifter_empty;
  logic              rx_push;
  logic              rx_pop;
  logic              rx_avail;
  logic              tx_evt;
  logic              rx_evt;
  usc_rx_char_t      rx_head;
  logic              pin_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == OFS_STAT_CTRL);
  assign wr_txd  = bus_req_in.wr && (bus_req_in.addr == OFS_TX_DATA);
  assign rd_rxd  = bus_req_in.rd && (bus_req_in.addr == OFS_RX_DATA);

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  assign tx_full       = (tx_cnt_q == DEPTH_C); // RULE_14
  assign tx_push       = wr_txd && txen_q && !tx_full;
  // A pending break goes first so the request is honoured on the next frame
  assign break_start   = txen_q && break_q && !break_active_q && !tx_busy;
  assign tx_load       = txen_q && !tx_busy && !break_start && !break_active_q
                         && (tx_cnt_q != 3'h0);
  assign shifter_empty = !tx_busy && (tx_cnt_q == 3'h0) && !break_active_q; // RULE_10

  usc_tx_shift #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx_shift (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .abort_in   (!txen_q),
    .start_in   (tx_load || break_start),
    .break_in   (break_start),
    .data_in    (tx_mem[tx_rp_q]),
    .busy_out   (tx_busy),
    .done_out   (tx_done),
    .line_out   (tx_line)
  );

  always_ff @(posedge clk_sys_in) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= bus_req_in.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_wp_q  <= 2'h0;
      tx_rp_q  <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else if (!txen_q) begin
      tx_wp_q  <= 2'h0; // RULE_09
      tx_rp_q  <= 2'h0;
      tx_cnt_q <= 3'h0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 2'h1;
      end
      if (tx_load) begin
        tx_rp_q <= tx_rp_q + 2'h1;
      end
      tx_cnt_q <= tx_cnt_q + {2'h0, tx_push} - {2'h0, tx_load};
    end
  end

  // ----------------------------------------------------------------
  // Transmit interrupt source
  // ----------------------------------------------------------------
  always_comb begin
    case (tx_mode_q)
      TXM_EACH:  tx_evt = tx_load; // RULE_04
      TXM_DONE:  tx_evt = tx_done && !break_active_q && (tx_cnt_q == 3'h0); // RULE_03
      TXM_EMPTY: tx_evt = tx_load && (tx_cnt_q == 3'h1) && !tx_push; // RULE_02
      default:   tx_evt = 1'b0; // RULE_01
    endcase
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  assign rx_avail    = (rx_cnt_q != 3'h0);
  assign rx_pop      = rd_rxd && rx_avail;
  assign rx_push     = rx_char_valid_in && (!(rx_cnt_q == DEPTH_C) || rx_pop);
  assign rx_cnt_next = rx_cnt_q + {2'h0, rx_push} - {2'h0, rx_pop};
  assign rx_head     = rx_mem[rx_rp_q];

  always_ff @(posedge clk_sys_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_char_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_wp_q  <= 2'h0;
      rx_rp_q  <= 2'h0;
      rx_cnt_q <= 3'h0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 2'h1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 2'h1;
      end
      rx_cnt_q <= rx_cnt_next;
    end
  end

  always_comb begin
    if (!rx_push) begin
      rx_evt = 1'b0;
    end else if (rx_mode_q == RXM_FULL) begin
      rx_evt = (rx_cnt_next == DEPTH_C); // RULE_11
    end else if (rx_mode_q == RXM_3Q) begin
      rx_evt = (rx_cnt_next == LVL_3Q); // RULE_12
    end else begin
      rx_evt = 1'b1; // RULE_13
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_mode_q   <= RST_MODE;
      tx_invert_q <= 1'b0;
      txen_q      <= 1'b0;
      rx_mode_q   <= RST_MODE;
      addr_det_q  <= 1'b0;
      ir_en_q     <= 1'b0;
      irq_mask_q  <= RST_IRQ_MASK;
    end else begin
      if (wr_ctrl) begin
        tx_mode_q   <= {bus_req_in.wdata[BIT_TXM_HI], bus_req_in.wdata[BIT_TXM_LO]};
        tx_invert_q <= bus_req_in.wdata[BIT_TX_INV];
        txen_q      <= bus_req_in.wdata[BIT_TXEN];
        rx_mode_q   <= bus_req_in.wdata[BIT_RXM_HI:BIT_RXM_LO];
        addr_det_q  <= bus_req_in.wdata[BIT_ADDR_DET];
      end
      if (bus_req_in.wr && (bus_req_in.addr == OFS_EXT_CTRL)) begin
        ir_en_q <= bus_req_in.wdata[BIT_IR_EN];
      end
      if (bus_req_in.wr && (bus_req_in.addr == OFS_IRQ_MASK)) begin
        irq_mask_q <= bus_req_in.wdata[IRQ_W-1:0];
      end
    end
  end

  // Break request: software sets, hardware clears after the break frame
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      break_q        <= 1'b0;
      break_active_q <= 1'b0;
    end else begin
      if (!txen_q) begin
        break_active_q <= 1'b0;
      end else if (break_start) begin
        break_active_q <= 1'b1;
      end else if (tx_done) begin
        break_active_q <= 1'b0;
      end
      if (wr_ctrl && bus_req_in.wdata[BIT_BREAK]) begin
        break_q <= 1'b1;
      end else if (tx_done && break_active_q) begin
        break_q <= 1'b0; // RULE_07
      end else if (wr_ctrl) begin
        break_q <= 1'b0;
      end
    end
  end

  // Overrun only clears on a written zero, and a new overrun beats the clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overrun_q <= 1'b0;
    end else if (rx_char_valid_in && !rx_push) begin
      overrun_q <= 1'b1;
    end else if (wr_ctrl && !bus_req_in.wdata[BIT_OVERRUN]) begin
      overrun_q <= 1'b0; // RULE_15
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  assign irq_evt = {rx_push && (rx_char_in.parity_err || rx_char_in.framing_err),
                    rx_char_valid_in && !rx_push, rx_evt, tx_evt};

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_q <= '0;
    end else if (bus_req_in.wr && (bus_req_in.addr == OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~bus_req_in.wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_q <= '0;
    end else if (bus_req_in.rd) begin
      rd_data_q <= '0;
      if (bus_req_in.addr == OFS_STAT_CTRL) begin
        rd_data_q[BIT_TXM_HI]   <= tx_mode_q[1];
        rd_data_q[BIT_TX_INV]   <= tx_invert_q;
        rd_data_q[BIT_TXM_LO]   <= tx_mode_q[0];
        rd_data_q[BIT_BREAK]    <= break_q;
        rd_data_q[BIT_TXEN]     <= txen_q;
        rd_data_q[BIT_TXBF]     <= tx_full; // RULE_14
        rd_data_q[BIT_SHIFT_MT] <= shifter_empty; // RULE_10
        rd_data_q[BIT_RXM_HI:BIT_RXM_LO] <= rx_mode_q;
        rd_data_q[BIT_ADDR_DET] <= addr_det_q;
        rd_data_q[BIT_RX_IDLE]  <= rx_line_idle_in; // RULE_15
        rd_data_q[BIT_PAR_ERR]  <= rx_avail && rx_head.parity_err;
        rd_data_q[BIT_FRM_ERR]  <= rx_avail && rx_head.framing_err;
        rd_data_q[BIT_OVERRUN]  <= overrun_q;
        rd_data_q[BIT_RX_AVAIL] <= rx_avail;
      end else if (bus_req_in.addr == OFS_IRQ_STAT) begin
        rd_data_q[IRQ_W-1:0] <= irq_stat_q;
      end else if (bus_req_in.addr == OFS_IRQ_MASK) begin
        rd_data_q[IRQ_W-1:0] <= irq_mask_q;
      end else if (bus_req_in.addr == OFS_RX_DATA) begin
        rd_data_q[DATA_BITS-1:0] <= rx_avail ? rx_head.data : 8'h00;
      end else if (bus_req_in.addr == OFS_EXT_CTRL) begin
        rd_data_q[BIT_IR_EN] <= ir_en_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit pin
  // ----------------------------------------------------------------
  // The infrared form here pulses for every zero bit; pulse shaping is left
  // to the optical front end, only the idle level is set by the invert bit.
  always_comb begin
    if (!txen_q) begin
      pin_d = port_tx_value_in; // RULE_09
    end else if (ir_en_q) begin
      pin_d = !tx_line ^ tx_invert_q; // RULE_05
    end else begin
      pin_d = tx_line ^ tx_invert_q; // RULE_05
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_q   <= 1'b1;
      owned_q <= 1'b0;
    end else begin
      pin_q   <= pin_d;
      owned_q <= txen_q; // RULE_08
    end
  end

  assign rd_data_out       = rd_data_q;
  assign irq_out           = irq_q;
  assign serial_tx_pin_out = pin_q;
  assign tx_pin_owned_out  = owned_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  reserved_tx_mode_a: assert property ( // RULE_01
    (tx_mode_q == TXM_RSVD) && !irq_stat_q[IRQ_TX] |=> !irq_stat_q[IRQ_TX])
    else $error("reserved transmit mode raised an interrupt");
  tx_empty_mode_a: assert property ( // RULE_02
    (tx_mode_q == TXM_EMPTY) && tx_load && (tx_cnt_q == 3'h1) && !tx_push
    |=> irq_stat_q[IRQ_TX])
    else $error("buffer-empty transmit interrupt missing");
  tx_done_mode_a: assert property ( // RULE_03
    (tx_mode_q == TXM_DONE) && tx_load |=> !tx_evt [*3])
    else $error("completion mode fired while shifting");
  tx_each_mode_a: assert property ( // RULE_04
    (tx_mode_q == TXM_EACH) && tx_load |=> irq_stat_q[IRQ_TX])
    else $error("per-character transmit interrupt missing");
  idle_level_a: assert property ( // RULE_05
    txen_q && !ir_en_q && !tx_busy && !break_active_q && $stable(tx_invert_q)
    |=> serial_tx_pin_out == !$past(tx_invert_q))
    else $error("transmit idle level wrong");
  break_frame_a: assert property ( // RULE_06
    break_start |=> ##BRK_LOW_LAST (!tx_line || !txen_q))
    else $error("break frame ended too early");
  break_clear_a: assert property ( // RULE_07
    tx_done && break_active_q && !wr_ctrl |=> !break_q)
    else $error("break request not cleared after break");
  pin_owner_a: assert property ( // RULE_08
    txen_q |=> tx_pin_owned_out)
    else $error("transceiver not owning the pin");
  abort_flush_a: assert property ( // RULE_09
    !txen_q |=> (tx_cnt_q == 3'h0) && !tx_busy && (serial_tx_pin_out == $past(port_tx_value_in)))
    else $error("disable did not abort and release the pin");
  shifter_flag_a: assert property ( // RULE_10
    tx_busy || tx_cnt_q != 3'h0 |-> !shifter_empty)
    else $error("shifter-empty set while busy");
  rx_full_mode_a: assert property ( // RULE_11
    (rx_mode_q == RXM_FULL) && rx_push && !rx_pop && (rx_cnt_q == 3'h3) |=> irq_stat_q[IRQ_RX])
    else $error("receive full interrupt missing");
  rx_full_early_a: assert property ( // RULE_11
    (rx_mode_q == RXM_FULL) && rx_push && (rx_cnt_next != DEPTH_C) |-> !irq_evt[IRQ_RX])
    else $error("receive full mode fired early");
  rx_3q_mode_a: assert property ( // RULE_12
    (rx_mode_q == RXM_3Q) && rx_push && !rx_pop && (rx_cnt_q == 3'h2) |=> irq_stat_q[IRQ_RX])
    else $error("three-quarter receive interrupt missing");
  rx_each_mode_a: assert property ( // RULE_13
    !rx_mode_q[1] && rx_push |=> irq_stat_q[IRQ_RX])
    else $error("per-character receive interrupt missing");
  tx_full_a: assert property ( // RULE_14
    txen_q && tx_full && wr_txd && !tx_load |=> tx_cnt_q == DEPTH_C)
    else $error("write accepted into a full buffer");
  overrun_set_a: assert property ( // RULE_15
    rx_char_valid_in && (rx_cnt_q == DEPTH_C) && !rx_pop |=> overrun_q ##1
    (overrun_q || ($past(wr_ctrl) && !$past(bus_req_in.wdata[BIT_OVERRUN]))))
    else $error("overrun not held");
endmodule // usc_status_control

// File: usc_status_control_tb.sv
// Self-checking testbench of the serial status and control block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module usc_status_control_tb;
  import usc_pkg::*;
  localparam int unsigned BC = 4;
  logic clk_sys_in, reset_n_in, rx_char_valid_in, rx_line_idle_in, port_tx_value_in;
  logic serial_tx_pin_out, tx_pin_owned_out, irq_out;
  usc_bus_req_t bus_req_in;
  usc_rx_char_t rx_char_in;
  logic [15:0] rd_data_out, q, c;
  logic [7:0] rx_byte, d;
  int frames, failures = 0, check_count = 0, cycles = 0, low, rxq[$];
  usc_status_control #(.BIT_CYCLES(BC)) u_dut (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .bus_req_in(bus_req_in), .rd_data_out(rd_data_out),
    .rx_char_valid_in(rx_char_valid_in), .rx_char_in(rx_char_in),
    .rx_line_idle_in(rx_line_idle_in), .port_tx_value_in(port_tx_value_in),
    .serial_tx_pin_out(serial_tx_pin_out), .tx_pin_owned_out(tx_pin_owned_out),
    .irq_out(irq_out));
  usc_remote_node #(.BC(BC)) u_node (.clk_in(clk_sys_in), .line_in(serial_tx_pin_out),
    .byte_out(rx_byte), .frames_out(frames));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Ceiling well above the under one thousand cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    bus_req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus_req_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys_in);
    bus_req_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus_req_in.rd <= 1'b0;
    #1 q = rd_data_out;
  endtask
  task automatic push(input logic [7:0] v, input logic e);
    @(posedge clk_sys_in);
    rx_char_valid_in <= 1'b1;
    rx_char_in <= '{data: v, parity_err: e, framing_err: 1'b0};
    @(posedge clk_sys_in);
    rx_char_valid_in <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(OFS_STAT_CTRL);
      if (q[BIT_SHIFT_MT]) break;
    end
  endtask
  initial begin
    void'($urandom(32'h4f752019));
    reset_n_in = 1'b0;
    bus_req_in = '0;
    rx_char_valid_in = 1'b0;
    rx_char_in = '0;
    rx_line_idle_in = 1'b1;
    port_tx_value_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(OFS_STAT_CTRL);
    `CHK(q, 16'h0110)
    rd(3'h6);
    `CHK(q, 16'h0000)
    wr(OFS_IRQ_MASK, 16'h000f);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_STAT_CTRL, 16'h0400 | (16'(m >> 1) << 15) | (16'(m & 1) << 13));
      wr(OFS_IRQ_STAT, 16'h000f);
      d = 8'($urandom);
      wr(OFS_TX_DATA, {8'h00, d});
      rd(OFS_STAT_CTRL);
      `CHK(q[BIT_SHIFT_MT], 1'b0)
      wait_idle();
      `CHK(rx_byte, d)
      rd(OFS_IRQ_STAT);
      `CHK(q[IRQ_TX], m != 3)
      `CHK(irq_out, m != 3)
    end
    // Shifter takes the first, four more fill the buffer
    for (int i = 0; i < 5; i++) wr(OFS_TX_DATA, 16'(8'($urandom)));
    rd(OFS_STAT_CTRL);
    `CHK(q[BIT_TXBF], 1'b1)
    wait_idle();
    wr(OFS_STAT_CTRL, 16'h0c00);
    low = 0;
    repeat (120) begin
      @(posedge clk_sys_in);
      #1 low += !serial_tx_pin_out;
    end
    `CHK(low, 13 * BC)
    rd(OFS_STAT_CTRL);
    `CHK(q[BIT_BREAK], 1'b0)
    `CHK(frames, 10)
    for (int r = 0; r < 3; r++) begin
      c = 16'h0400 | (16'(r + (r > 0)) << 6);
      wr(OFS_STAT_CTRL, c);
      for (int k = 1; k < 6; k++) begin
        wr(OFS_IRQ_STAT, 16'h000f);
        d = 8'($urandom);
        push(d, k == 1);
        if (k < 5) rxq.push_back(d);
        rd(OFS_IRQ_STAT);
        `CHK(q[IRQ_RX], k < 5 && (r == 0 || k == r + 2))
        `CHK(q[IRQ_RX_ERR], k == 1)
        `CHK(q[IRQ_OVERRUN], k == 5)
      end
      rd(OFS_STAT_CTRL);
      `CHK(q[BIT_OVERRUN], 1'b1)
      `CHK(q[BIT_PAR_ERR], 1'b1)
      wr(OFS_STAT_CTRL, c);
      rd(OFS_STAT_CTRL);
      `CHK(q[BIT_OVERRUN], 1'b0)
      while (rxq.size() > 0) begin
        rd(OFS_RX_DATA);
        d = 8'(rxq.pop_front());
        `CHK(q[7:0], d)
      end
    end
    wr(OFS_STAT_CTRL, 16'h4400);
    rd(OFS_STAT_CTRL);
    `CHK(serial_tx_pin_out, 1'b0)
    `CHK(tx_pin_owned_out, 1'b1)
    wr(OFS_EXT_CTRL, 16'h0001);
    rd(OFS_EXT_CTRL);
    `CHK(q[BIT_IR_EN], 1'b1)
    `CHK(serial_tx_pin_out, 1'b1)
    @(posedge clk_sys_in);
    port_tx_value_in <= 1'b0;
    wr(OFS_STAT_CTRL, 16'h0000);
    rd(OFS_STAT_CTRL);
    `CHK(serial_tx_pin_out, 1'b0)
    `CHK(tx_pin_owned_out, 1'b0)
    summarize();
  end
endmodule // usc_status_control_tb

// File: usc_tx_shift.sv
// Transmit shifter that sends a data frame or a sync break frame
`timescale 1ns/100ps
module usc_tx_shift #(
  parameter int unsigned BIT_CYCLES = usc_pkg::BIT_CYCLES
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       abort_in,
  input  wire logic       start_in,
  input  wire logic       break_in,
  input  wire logic [7:0] data_in,
  output logic            busy_out,
  output logic            done_out,
  output logic            line_out
);
  import usc_pkg::*;

  typedef enum logic {USC_IDLE, USC_SHIFT} usc_tx_state_t;

  localparam int unsigned FRAME_W = BREAK_ZEROS + 2;

  usc_tx_state_t        state_q;
  logic [FRAME_W-1:0]   frame_q;
  logic [3:0]           left_q;
  logic [15:0]          div_q;
  logic                 done_q;
  logic                 bit_tick;

  // ----------------------------------------------------------------
  // Bit-rate enable pulse
  // ----------------------------------------------------------------
  assign bit_tick = (div_q == 16'(BIT_CYCLES - 1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= USC_IDLE;
      frame_q <= '1;
      left_q  <= 4'h0;
      div_q   <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort_in) begin
        // Dropping mid-frame returns the line to idle at once
        state_q <= USC_IDLE;
        frame_q <= '1;
        left_q  <= 4'h0;
        div_q   <= 16'h0000;
      end else begin
        case (state_q)
          USC_IDLE: begin
            if (start_in) begin
              div_q   <= 16'h0000;
              state_q <= USC_SHIFT;
              if (break_in) begin
                frame_q <= {1'b1, {BREAK_ZEROS{1'b0}}, 1'b0}; // RULE_06
                left_q  <= 4'(BREAK_ZEROS + 2);
              end else begin
                frame_q <= {{(FRAME_W - DATA_BITS - 1){1'b1}}, data_in, 1'b0};
                left_q  <= 4'(DATA_BITS + 2);
              end
            end
          end
          USC_SHIFT: begin
            if (bit_tick) begin
              div_q   <= 16'h0000;
              frame_q <= {1'b1, frame_q[FRAME_W-1:1]};
              left_q  <= left_q - 4'h1;
              if (left_q == 4'h1) begin
                state_q <= USC_IDLE;
                done_q  <= 1'b1;
              end
            end else begin
              div_q <= div_q + 16'h0001;
            end
          end
          default: state_q <= USC_IDLE;
        endcase
      end
    end
  end

  assign busy_out = (state_q == USC_SHIFT);
  assign done_out = done_q;
  assign line_out = frame_q[0];
endmodule // usc_tx_shift
